// ### verilog/sbi_pkg.sv
/*
 * sbi_pkg: shared constants and carrier types for the buffer credit and
 * interrupt mask block of the spi mac-phy.
 * assumes the spi engine decodes frames into word-indexed register accesses.
 */
package sbi_pkg;

	// ----------------------------------------------------------------
	// register indices (word addresses as seen by the spi host)
	// ----------------------------------------------------------------
	localparam logic [7:0]  BUF_CREDIT_IDX    = 8'h0b;
	localparam logic [7:0]  FOOTER_MASK_IDX   = 8'h0c;
	localparam logic [7:0]  IRQ_MASK_IDX      = 8'h0d;

	// ----------------------------------------------------------------
	// field layouts and reset values
	// ----------------------------------------------------------------
	localparam int          EVT_W             = 13;
	localparam int          TXC_LSB           = 8;
	localparam int          RCA_LSB           = 0;
	localparam int          CNT_W             = 8;
	localparam int          FOOTER_TXC_W      = 5;
	localparam logic [7:0]  TX_CREDIT_RESET   = 8'h77;
	localparam logic [7:0]  TXC_FOOTER_MAX    = 8'h1f;
	localparam logic [31:0] BUF_CREDIT_RESET  = 32'h0000_7700;
	localparam logic [31:0] FOOTER_MASK_RESET = 32'h0000_1fbf;
	localparam logic [31:0] IRQ_MASK_RESET    = 32'h43fa_1f1a;
	localparam int          MASK_HI_LSB       = 13;
	localparam logic [18:0] IRQ_MASK_UPPER    = 19'h21fd0;

	// footer mask: bit 6 (reset-done slot) is read-only zero
	localparam logic [12:0] FOOTER_MASK_WR    = 13'h1fbf;
	localparam int          RESET_DONE_BIT    = 6;
	// irq-pin mask: 12,11,10,9(spare),8,4,3,1 are writable
	localparam logic [12:0] IRQ_MASK_WR       = 13'h1f1a;

	// event bit positions within the two status images
	localparam logic [12:0] EVT0_USED         = 13'h1fff;
	localparam logic [12:0] EVT1_USED         = 13'h1d1a;
	localparam logic [12:0] EVT0_CHUNK_ONLY   = 13'h1020;
	localparam logic [12:0] EVT1_GENERIC_ONLY = 13'h0418;
	localparam int          SPI_ERR_BIT       = 10;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [EVT_W-1:0] s1;
		logic [EVT_W-1:0] s0;
	} sbi_evt_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} sbi_reg_req_t;

endpackage

// ### verilog/sbi_sticky_bank.sv
/*
 * sbi_sticky_bank: a row of event flags, set by a pulse and cleared by a
 * write-one strobe; a set in the same cycle as its clear wins.
 * assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module sbi_sticky_bank #(
	parameter int W = 13
) (
	input  wire logic         i_ref_clk,  // system clock
	input  wire logic         i_nrst,     // async reset, active low
	input  wire logic [W-1:0] i_set,      // event pulses
	input  wire logic [W-1:0] i_clr,      // write-one-to-clear strobes
	output logic      [W-1:0] o_flags     // held flags
);

	logic [W-1:0] flags_q;

	generate
		for (genvar g = 0; g < W; g++) begin : g_flag
			// an event meeting its own clear is not lost
			always_ff @(posedge i_ref_clk or negedge i_nrst) begin
				if (!i_nrst)
					flags_q[g] <= 1'b0;
				else if (i_set[g])
					flags_q[g] <= 1'b1;
				else if (i_clr[g])
					flags_q[g] <= 1'b0;
			end
		end
	endgenerate

	assign o_flags = flags_q;

endmodule

// ### verilog/sbi_credit_irq.sv
/*
 * sbi_credit_irq: buffer credit status, footer event mask and irq-pin event
 * mask of the spi mac-phy, with the event flags they gate.
 * assumes the spi engine hands over decoded register accesses on the system
 * clock, and that fifo logic pulses the chunk and event inputs on that clock.
 */
`timescale 1ns/1ps
module sbi_credit_irq
	import sbi_pkg::*;
#(
	parameter logic [7:0] TX_CREDIT_MAX = TX_CREDIT_RESET,
	parameter logic [7:0] RX_CHUNK_MAX  = 8'hff
) (
	input  wire logic         i_ref_clk,         // 25 MHz system clock
	input  wire logic         i_nrst,            // async reset, active low
	input  wire logic         i_generic_spi,     // 1: generic spi, 0: chunk protocol
	input  wire sbi_reg_req_t i_reg,             // decoded register access
	output logic [31:0]       o_reg_rdata,       // read data, one cycle after rd
	input  wire logic         i_tx_chunk_used,   // host filled a tx chunk buffer
	input  wire logic         i_tx_chunk_freed,  // a tx chunk buffer drained
	input  wire logic         i_rx_chunk_ready,  // a new rx chunk is queued
	input  wire logic         i_rx_chunk_read,   // host took an rx chunk
	input  wire sbi_evt_t     i_evt_set,         // event pulses, status layout
	input  wire sbi_evt_t     i_evt_clr,         // write-one-to-clear strobes
	output sbi_evt_t          o_evt_status,      // held event flags
	output logic [4:0]        o_footer_txc,      // txc field for rx footers
	output logic              o_footer_exst,     // exst bit for rx footers
	output logic              o_interrupt_pin_n  // interrupt pin, active low
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (TX_CREDIT_MAX == 8'h00) begin : g_bad_tx
			$error("tx credit maximum must be non-zero");
		end
		if (RX_CHUNK_MAX == 8'h00) begin : g_bad_rx
			$error("rx chunk maximum must be non-zero");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
		reg_hit = (addr == idx);
	endfunction

	function automatic logic [7:0] step_cnt(input logic [7:0] cnt, input logic inc,
		input logic dec, input logic [7:0] top);
		step_cnt = cnt;
		if (inc && !dec && cnt < top)
			step_cnt = cnt + 8'h01;
		else if (dec && !inc && cnt != 8'h00)
			step_cnt = cnt - 8'h01;
	endfunction

	// ----------------------------------------------------------------
	// credit counters
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] tx_credit_q;
	logic [CNT_W-1:0] rx_chunks_q;
	logic [4:0]       footer_txc_d;

	// counts saturate at both ends rather than wrap: a stray pulse from the
	// fifo side must never turn an empty buffer into a full one
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			tx_credit_q <= TX_CREDIT_RESET;
		else
			tx_credit_q <= step_cnt(tx_credit_q, i_tx_chunk_freed, i_tx_chunk_used, TX_CREDIT_MAX);
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			rx_chunks_q <= 8'h00;
		else
			rx_chunks_q <= step_cnt(rx_chunks_q, i_rx_chunk_ready, i_rx_chunk_read, RX_CHUNK_MAX);
	end

	// footer has only five bits, so the count is held at 31
	always_comb begin
		if (tx_credit_q > TXC_FOOTER_MAX)
			footer_txc_d = TXC_FOOTER_MAX[4:0];
		else
			footer_txc_d = tx_credit_q[4:0];
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_footer_txc <= TXC_FOOTER_MAX[4:0];
		else
			o_footer_txc <= footer_txc_d;
	end

	// ----------------------------------------------------------------
	// mask registers
	// ----------------------------------------------------------------
	logic [EVT_W-1:0] footer_mask_q;
	logic [EVT_W-1:0] irq_mask_q;

	// only the writable bits take the write; bit 6 of the footer mask stays 0
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			footer_mask_q <= FOOTER_MASK_RESET[EVT_W-1:0];
		else if (i_reg.wr && reg_hit(i_reg.addr, FOOTER_MASK_IDX))
			footer_mask_q <= i_reg.wdata[EVT_W-1:0] & FOOTER_MASK_WR;
	end

	// bit 8 is taken as the receive gap mask, matching its status bit
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			irq_mask_q <= IRQ_MASK_RESET[EVT_W-1:0];
		else if (i_reg.wr && reg_hit(i_reg.addr, IRQ_MASK_IDX))
			irq_mask_q <= i_reg.wdata[EVT_W-1:0] & IRQ_MASK_WR;
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_hit(i_reg.addr, BUF_CREDIT_IDX)) begin
			rdata_d[TXC_LSB +: CNT_W] = tx_credit_q;
			rdata_d[RCA_LSB +: CNT_W] = rx_chunks_q;
		end else if (reg_hit(i_reg.addr, FOOTER_MASK_IDX)) begin
			rdata_d[EVT_W-1:0] = footer_mask_q;
		end else if (reg_hit(i_reg.addr, IRQ_MASK_IDX)) begin
			rdata_d[EVT_W-1:0] = irq_mask_q;
			rdata_d[31:MASK_HI_LSB] = IRQ_MASK_UPPER;
		end
	end

	// unmapped indices read as zero; data holds until the next read
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_reg_rdata <= 32'h0000_0000;
		else if (i_reg.rd)
			o_reg_rdata <= rdata_d;
	end

	// ----------------------------------------------------------------
	// event flags
	// ----------------------------------------------------------------
	sbi_evt_t evt_q;

	sbi_sticky_bank #(
		.W (2 * EVT_W)
	) u_flags (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_set     ({i_evt_set.s1 & EVT1_USED, i_evt_set.s0 & EVT0_USED}),
		.i_clr     ({i_evt_clr.s1, i_evt_clr.s0}),
		.o_flags   (evt_q)
	);

	assign o_evt_status = evt_q;

	// ----------------------------------------------------------------
	// interrupt combine
	// ----------------------------------------------------------------
	logic [EVT_W-1:0] live0;
	logic [EVT_W-1:0] live1;
	logic             pend_d;
	logic             pend_q;

	// protocol-specific sources are dropped outright in the other protocol,
	// whatever their mask says
	always_comb begin
		live0 = evt_q.s0 & ~footer_mask_q;
		if (i_generic_spi)
			live0 = live0 & ~EVT0_CHUNK_ONLY;
		live1 = evt_q.s1 & ~irq_mask_q;
		if (!i_generic_spi)
			live1 = live1 & ~EVT1_GENERIC_ONLY;
		pend_d = (|live0) | (|live1);
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			pend_q <= 1'b0;
		else
			pend_q <= pend_d;
	end

	// pin and footer bit share one flop so they can never disagree
	assign o_interrupt_pin_n = ~pend_q;
	assign o_footer_exst     = pend_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic seen_q;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			seen_q <= 1'b0;
		else
			seen_q <= 1'b1;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_read(logic [7:0] idx);
		i_reg.rd && i_reg.addr == idx;
	endsequence

	sequence s_quiet;
		!pend_d;
	endsequence

	sequence s_write(logic [7:0] idx);
		i_reg.wr && i_reg.addr == idx;
	endsequence

	// a count steps only when one side of the fifo moves alone and the
	// count is not already at the end it moves towards
	sequence s_rx_take;
		i_rx_chunk_read && !i_rx_chunk_ready && rx_chunks_q != 8'h00;
	endsequence

	sequence s_tx_fill;
		i_tx_chunk_used && !i_tx_chunk_freed && tx_credit_q != 8'h00;
	endsequence

	sequence s_tx_drain;
		i_tx_chunk_freed && !i_tx_chunk_used && tx_credit_q < TX_CREDIT_MAX;
	endsequence

	// reset-done has no mask: pulse, then flag, then pin
	sequence s_reset_done_walk;
		i_evt_set.s0[RESET_DONE_BIT] ##1 evt_q.s0[RESET_DONE_BIT];
	endsequence

	a_pin_exst_agree: assert property (o_footer_exst == !o_interrupt_pin_n)
		else $error("pin and footer exst disagree");

	a_quiet_releases: assert property (s_quiet |=> o_interrupt_pin_n)
		else $error("pin held with no unmasked flag");

	a_reset_done_pin: assert property (evt_q.s0[RESET_DONE_BIT] |=> !o_interrupt_pin_n)
		else $error("reset-done did not raise the pin");

	a_mask0_slot_zero: assert property (s_read(FOOTER_MASK_IDX) |=>
		!o_reg_rdata[RESET_DONE_BIT] && o_reg_rdata[31:13] == 19'h0)
		else $error("footer mask reserved bits not zero");

	a_mask1_upper: assert property (s_read(IRQ_MASK_IDX) |=> o_reg_rdata[31:13] == 19'h21fd0)
		else $error("irq mask upper field wrong");

	a_credit_read: assert property (s_read(BUF_CREDIT_IDX) |=>
		o_reg_rdata == {16'h0, $past(tx_credit_q), $past(rx_chunks_q)})
		else $error("credit register read wrong");

	a_rdata_holds: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");

	a_credit_start: assert property (!seen_q |-> tx_credit_q == 8'h77 && rx_chunks_q == 8'h00)
		else $error("credit counts wrong after reset");

	a_txc_clamp: assert property (tx_credit_q > 8'd31 |=> o_footer_txc == 5'd31)
		else $error("footer txc not clamped");

	a_rx_count_up: assert property (i_rx_chunk_ready && !i_rx_chunk_read && rx_chunks_q < RX_CHUNK_MAX
		|=> rx_chunks_q == $past(rx_chunks_q) + 8'h01)
		else $error("rx chunk count did not advance");

	a_rx_count_down: assert property (s_rx_take |=> rx_chunks_q == $past(rx_chunks_q) - 8'h01)
		else $error("rx chunk count did not drop");

	a_tx_count_down: assert property (s_tx_fill |=> tx_credit_q == $past(tx_credit_q) - 8'h01)
		else $error("tx credit did not drop");

	a_tx_count_up: assert property (s_tx_drain |=> tx_credit_q == $past(tx_credit_q) + 8'h01)
		else $error("tx credit did not return");

	a_set_wins: assert property (1'b1 |=> (evt_q.s0 & $past(i_evt_set.s0)) == $past(i_evt_set.s0))
		else $error("event lost against its clear");

	a_flag_holds: assert property (1'b1 |=>
		(evt_q.s0 & ($past(evt_q.s0) & ~$past(i_evt_clr.s0))) == ($past(evt_q.s0) & ~$past(i_evt_clr.s0)))
		else $error("event flag dropped without clear");

	a_clear_drops: assert property ((i_evt_clr.s0 & ~i_evt_set.s0) != 13'h0
		|=> (evt_q.s0 & $past(i_evt_clr.s0 & ~i_evt_set.s0)) == 13'h0)
		else $error("cleared flag stayed set");

	a_unused_s1_zero: assert property ((evt_q.s1 & ~EVT1_USED) == 13'h0)
		else $error("unused status bit set");

	a_mask0_write: assert property (s_write(FOOTER_MASK_IDX)
		|=> footer_mask_q == ($past(i_reg.wdata[12:0]) & 13'h1fbf))
		else $error("footer mask write wrong");

	a_mask1_write: assert property (s_write(IRQ_MASK_IDX)
		|=> irq_mask_q == ($past(i_reg.wdata[12:0]) & 13'h1f1a))
		else $error("irq mask write wrong");

	a_masks_hold: assert property (!i_reg.wr |=> $stable(footer_mask_q) && $stable(irq_mask_q))
		else $error("mask moved without a write");

	a_reset_done_walk: assert property (s_reset_done_walk |=> !o_interrupt_pin_n)
		else $error("reset-done pulse did not reach the pin");

	a_exst_follows: assert property (pend_d |=> o_footer_exst)
		else $error("exst low with an unmasked flag");

	// judged on the raw flags, so a broken protocol gate is caught
	a_spi_err_gated: assert property (!i_generic_spi && !(|live0)
		&& ((evt_q.s1 & ~irq_mask_q) & ~EVT1_GENERIC_ONLY) == 13'h0 |=> o_interrupt_pin_n)
		else $error("generic-only source raised the pin");

	a_chunk_src_gated: assert property (i_generic_spi && !(|live1)
		&& ((evt_q.s0 & ~footer_mask_q) & ~EVT0_CHUNK_ONLY) == 13'h0 |=> o_interrupt_pin_n)
		else $error("chunk-only source raised the pin");

endmodule

// ### dv/sbi_host_model.sv
/*
 * sbi_host_model: spi host side of the block, issuing decoded register
 * accesses and write-one-to-clear strobes to the event flags.
 * assumes read data lands on the same edge that takes the read strobe.
 */
`timescale 1ns/1ps
module sbi_host_model
	import sbi_pkg::*;
(
	input  wire logic        i_ref_clk,  // system clock
	input  wire logic [31:0] i_rdata,    // register read data
	output sbi_reg_req_t     o_reg,      // decoded register access
	output sbi_evt_t         o_evt_clr   // write-one-to-clear strobes
);
	initial begin
		o_reg = '0;
		o_evt_clr = '0;
	end

	// ----------------------------------------------------------------
	// one word per access, strobes high for exactly one taken edge
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_ref_clk);
		o_reg <= '0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		o_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge i_ref_clk);
		o_reg <= '0;
		#1;
		d = i_rdata;
	endtask

	// flags stay up until the host writes one to them
	task automatic clr(input sbi_evt_t m);
		@(posedge i_ref_clk);
		o_evt_clr <= m;
		@(posedge i_ref_clk);
		o_evt_clr <= '0;
	endtask
endmodule

// ### dv/tb.sv
/*
 * tb: self-checking bench for the credit and event mask block.
 * assumes the host model drives the register port and the bench pulses
 * the chunk counters and event sources directly.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
	import sbi_pkg::*;
	logic         clk;
	logic         nrst;
	logic         generic;
	logic         used, freed, rdy, rdn;
	sbi_evt_t     evt_set, evt_clr, status;
	sbi_reg_req_t req;
	logic [31:0]  rdata;
	logic [4:0]   txc;
	logic         exst, pin_n;
	int           failures, n_compared;
	localparam int S1_SRC [7] = '{12, 11, 10, 8, 4, 3, 1};

	sbi_credit_irq uut (.i_ref_clk(clk), .i_nrst(nrst), .i_generic_spi(generic), .i_reg(req),
		.o_reg_rdata(rdata), .i_tx_chunk_used(used), .i_tx_chunk_freed(freed),
		.i_rx_chunk_ready(rdy), .i_rx_chunk_read(rdn), .i_evt_set(evt_set), .i_evt_clr(evt_clr),
		.o_evt_status(status), .o_footer_txc(txc), .o_footer_exst(exst), .o_interrupt_pin_n(pin_n));
	sbi_host_model host (.i_ref_clk(clk), .i_rdata(rdata), .o_reg(req), .o_evt_clr(evt_clr));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		host.reg_rd(BUF_CREDIT_IDX, d);
		`CHK("credit reset", BUF_CREDIT_RESET, d)
		host.reg_rd(FOOTER_MASK_IDX, d);
		`CHK("footer mask reset", FOOTER_MASK_RESET, d)
		host.reg_rd(IRQ_MASK_IDX, d);
		`CHK("irq mask reset", IRQ_MASK_RESET, d)
		host.reg_rd(8'h0e, d);
		`CHK("unmapped", 32'h0, d)
		`CHK("txc reset", 5'h1f, txc)
		host.reg_wr(BUF_CREDIT_IDX, 32'hffff_ffff);
		host.reg_wr(FOOTER_MASK_IDX, 32'hffff_ffff);
		host.reg_wr(IRQ_MASK_IDX, 32'h0);
		host.reg_rd(BUF_CREDIT_IDX, d);
		`CHK("credit ro", BUF_CREDIT_RESET, d)
		host.reg_rd(FOOTER_MASK_IDX, d);
		`CHK("footer mask ones", FOOTER_MASK_RESET, d)
		host.reg_rd(IRQ_MASK_IDX, d);
		`CHK("irq mask zeros", {IRQ_MASK_UPPER, 13'h0}, d)
		host.reg_wr(IRQ_MASK_IDX, IRQ_MASK_RESET);
	endtask

	// credit starts at its ceiling, so the freed pulses must not lift it
	task automatic t_credit();
		logic [31:0] d;
		@(posedge clk);
		freed <= 1'b1;
		rdy <= 1'b1;
		repeat (3) @(posedge clk);
		freed <= 1'b0;
		rdy <= 1'b0;
		@(posedge clk);
		used <= 1'b1;
		repeat (88) @(posedge clk);
		used <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("txc at 31", 5'(TX_CREDIT_RESET - 8'd88), txc)
		@(posedge clk);
		used <= 1'b1;
		@(posedge clk);
		used <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("txc at 30", 5'(TX_CREDIT_RESET - 8'd89), txc)
		host.reg_rd(BUF_CREDIT_IDX, d);
		`CHK("credit fields", {16'h0, TX_CREDIT_RESET - 8'd89, 8'h03}, d)
		@(posedge clk);
		rdn <= 1'b1;
		repeat (d[7:0]) @(posedge clk);
		rdn <= 1'b0;
		host.reg_rd(BUF_CREDIT_IDX, d);
		`CHK("rx chunks drained", 8'h00, d[7:0])
	endtask

	// one source: held while masked (reset-done has no mask and raises the pin at once), raises the pin once unmasked, drops on clear
	task automatic chk_src(input logic sel, input int b);
		sbi_evt_t m;
		m = '0;
		if (sel) begin
			m.s1[b] = 1'b1;
		end else begin
			m.s0[b] = 1'b1;
		end
		@(posedge clk);
		generic <= sel;
		evt_set <= m;
		@(posedge clk);
		evt_set <= '0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("flag held", 1'b1, |(status & m))
		`CHK("pin masked", (!sel && b == RESET_DONE_BIT) ? 1'b0 : 1'b1, pin_n)
		host.reg_wr(FOOTER_MASK_IDX, sel ? FOOTER_MASK_RESET : FOOTER_MASK_RESET & ~(32'h1 << b));
		host.reg_wr(IRQ_MASK_IDX, sel ? IRQ_MASK_RESET & ~(32'h1 << b) : IRQ_MASK_RESET);
		repeat (2) @(posedge clk);
		#1;
		`CHK("pin open", 1'b0, pin_n)
		`CHK("exst open", 1'b1, exst)
		host.clr(m);
		repeat (3) @(posedge clk);
		#1;
		`CHK("flag cleared", 1'b0, |(status & m))
		`CHK("pin released", 1'b1, pin_n)
		`CHK("exst released", 1'b0, exst)
		host.reg_wr(FOOTER_MASK_IDX, FOOTER_MASK_RESET);
		host.reg_wr(IRQ_MASK_IDX, IRQ_MASK_RESET);
	endtask

	// a source of the other protocol stays off the pin with every mask open;
	// a pulse meeting its own clear keeps the flag
	task automatic t_gate(input logic sel, input int b);
		sbi_evt_t m;
		m = '0;
		if (sel) begin
			m.s1[b] = 1'b1;
		end else begin
			m.s0[b] = 1'b1;
		end
		host.reg_wr(FOOTER_MASK_IDX, 32'h0);
		host.reg_wr(IRQ_MASK_IDX, 32'h0);
		@(posedge clk);
		generic <= !sel;
		evt_set <= m;
		@(posedge clk);
		evt_set <= '0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("off-protocol flag", 1'b1, |(status & m))
		`CHK("off-protocol pin", 1'b1, pin_n)
		@(posedge clk);
		generic <= sel;
		repeat (2) @(posedge clk);
		#1;
		`CHK("own-protocol pin", 1'b0, pin_n)
		fork
			host.clr(m);
			begin
				@(posedge clk);
				evt_set <= m;
				@(posedge clk);
				evt_set <= '0;
			end
		join
		#1;
		`CHK("set beats clear", 1'b1, |(status & m))
		host.clr(m);
		repeat (3) @(posedge clk);
		#1;
		`CHK("gate flag cleared", 1'b0, |(status & m))
		`CHK("gate pin released", 1'b1, pin_n)
		host.reg_wr(FOOTER_MASK_IDX, FOOTER_MASK_RESET);
		host.reg_wr(IRQ_MASK_IDX, IRQ_MASK_RESET);
	endtask

	initial begin
		nrst = 1'b0;
		generic = 1'b0;
		used = 1'b0;
		freed = 1'b0;
		rdy = 1'b0;
		rdn = 1'b0;
		evt_set = '0;
		failures = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_credit();
		for (int b = 0; b < EVT_W; b++) begin
			chk_src(1'b0, b);
		end
		for (int i = 0; i < 7; i++) begin
			chk_src(1'b1, S1_SRC[i]);
		end
		t_gate(1'b0, 12);
		t_gate(1'b0, 5);
		t_gate(1'b1, 10);
		t_gate(1'b1, 4);
		t_gate(1'b1, 3);
		wrap_up();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule
